/* File: src/lcd_vcomp.sv */
// LCD supply setpoint control: pump settings, voltage codes, temperature readout and
// piecewise-linear temperature compensation, reached over AXI4-Lite.
// Assumes the sensor code input is stable whenever conversion is requested and for 8 ms.
//
// Behaviour
// - Pump runs only while enabled; 2-bit multiplier.
// - Two 9-bit codes: character and icon mode.
// - Setpoint is code plus factor, 30 mV steps.
// - Factor is 9-bit signed, zero at 20 C.
// - Codes span 0..1FFh; setpoint clamped at 16 V.
// - Sensor gives 8-bit temperature, readable by host.
// - Celsius equals 0.6275 times value minus 40.
// - Temperature resets to FFh meaning no measurement.
// - Measure every second while enabled, 8 ms each.
// - Optional smoothing filter on temperature results.
// - Offset applied only when compensation enabled.
// - Four regions, each with own 3-bit slope.
// - Slope codes decode to eight fixed factors.
// - Values 0..48 use first and second slopes.
// - Values 49..96 use second slope only.
// - Values 97..143 use third slope.
// - Values 144..230 use third and fourth slopes.
// - From 231 to 254 factor is held; FFh gives zero.
// - External supply ignores codes and compensation.
`timescale 1ns/1ps

module lcd_vcomp #(
    parameter int unsigned MEAS_CYC   = lcd_vcomp_pkg::MEAS_CYCLES,
    parameter int unsigned PERIOD_CYC = lcd_vcomp_pkg::PERIOD_CYCLES
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Temperature sensor
    input  wire logic [7:0]  sensor_code,
    output logic             sensor_active,
    // Charge pump and regulator
    output logic             pump_enable,
    output logic [1:0]       pump_multiplier_sel,
    output logic             internal_supply,
    output logic [9:0]       lcd_setpoint_code
);
    import lcd_vcomp_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic              aw_have;
        logic [7:0]        aw_addr;
        logic              w_have;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [7:0]        ctrl;
        logic [8:0]        code_char;
        logic [8:0]        code_icon;
        logic [11:0]       slope;
        logic [7:0]        temp;
        meas_t             meas;
        logic [TICK_W-1:0] tick;
        logic [CONV_W-1:0] conv;
        logic [8:0]        factor;
        logic [9:0]        setpoint;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == OFF_CTRL) || (a == OFF_CODE_CHAR) || (a == OFF_CODE_ICON) ||
                     (a == OFF_SLOPE) || (a == OFF_TEMP) || (a == OFF_STATUS);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // Slope factor in eighths, so every table entry is an exact integer.
    function automatic logic signed [13:0] slope8(input logic [2:0] code);
        unique case (code)
            3'h0: slope8 = 14'sd0;
            3'h1: slope8 = -14'sd1;
            3'h2: slope8 = -14'sd2;
            3'h3: slope8 = -14'sd4;
            3'h4: slope8 = -14'sd10;
            3'h5: slope8 = 14'sd1;
            3'h6: slope8 = 14'sd2;
            3'h7: slope8 = 14'sd4;
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic [31:0]       wr_word;
    logic [31:0]       old_word;
    logic signed [13:0] sa;
    logic signed [13:0] sb;
    logic signed [13:0] sc;
    logic signed [13:0] sd;
    logic signed [13:0] t;
    logic signed [13:0] acc8;
    logic signed [13:0] rnd;
    logic signed [10:0] sum;
    logic [8:0]        active;
    logic [7:0]        sample;

    assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_have && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;

    always_comb begin
        st_nxt   = st_r;
        aw_take  = s_axi_awvalid && s_axi_awready;
        w_take   = s_axi_wvalid && s_axi_wready;
        ar_take  = s_axi_arvalid && s_axi_arready;
        old_word = 32'h0000_0000;
        wr_word  = 32'h0000_0000;
        sample   = sensor_code;

        // Write channel: address and data are taken independently, in either order.
        if (aw_take) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.aw_have && st_r.w_have) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = reg_mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st_r.aw_addr)
                OFF_CTRL:      old_word = {24'h0, st_r.ctrl};
                OFF_CODE_CHAR: old_word = {23'h0, st_r.code_char};
                OFF_CODE_ICON: old_word = {23'h0, st_r.code_icon};
                OFF_SLOPE:     old_word = {20'h0, st_r.slope};
                default:       old_word = 32'h0000_0000;
            endcase
            wr_word = merge(old_word, st_r.w_data, st_r.w_strb);
            unique case (st_r.aw_addr)
                OFF_CTRL:      st_nxt.ctrl      = wr_word[7:0];
                OFF_CODE_CHAR: st_nxt.code_char = wr_word[8:0];
                OFF_CODE_ICON: st_nxt.code_icon = wr_word[8:0];
                OFF_SLOPE:     st_nxt.slope     = wr_word[11:0];
                default:       st_nxt.slope     = st_r.slope;
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel: one-cycle registered answer.
        if (ar_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFF_CTRL:      st_nxt.rdata = {24'h0, st_r.ctrl};
                OFF_CODE_CHAR: st_nxt.rdata = {23'h0, st_r.code_char};
                OFF_CODE_ICON: st_nxt.rdata = {23'h0, st_r.code_icon};
                OFF_SLOPE:     st_nxt.rdata = {20'h0, st_r.slope};
                OFF_TEMP:      st_nxt.rdata = {24'h0, st_r.temp};
                OFF_STATUS:    st_nxt.rdata = {st_r.meas != M_IDLE, 5'h0, st_r.setpoint,
                                               7'h0, st_r.factor};
                default:       st_nxt.rdata = 32'h0000_0000;
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // ************************************************************
        // Periodic measurement
        // ************************************************************
        // The tick restarts at zero whenever measurement is off, so enabling it
        // starts a conversion at once rather than up to a second later.
        if (!st_r.ctrl[BIT_MEAS_EN]) begin
            st_nxt.tick = '0;
        end else if (st_r.tick == TICK_W'(PERIOD_CYC - 1)) begin
            st_nxt.tick = '0;
        end else begin
            st_nxt.tick = st_r.tick + TICK_W'(1);
        end
        unique case (st_r.meas)
            M_IDLE: begin
                if (st_r.ctrl[BIT_MEAS_EN] && st_r.tick == '0) begin
                    st_nxt.meas = M_CONV;
                    st_nxt.conv = '0;
                end
            end
            M_CONV: begin
                if (st_r.conv == CONV_W'(MEAS_CYC - 1)) begin
                    st_nxt.meas = M_LOAD;
                end else begin
                    st_nxt.conv = st_r.conv + CONV_W'(1);
                end
            end
            M_LOAD: begin
                st_nxt.meas = M_IDLE;
                // Filter weights the new sample by a quarter; the first result is taken raw.
                if (st_r.ctrl[BIT_FILT_EN] && st_r.temp != TEMP_NONE) begin
                    st_nxt.temp = 8'(({2'b00, st_r.temp} * 10'd3 + {2'b00, sample}
                                      + 10'd2) >> 2);
                end else begin
                    st_nxt.temp = sample;
                end
            end
            default: st_nxt.meas = M_IDLE;
        endcase

        // ************************************************************
        // Compensation factor
        // ************************************************************
        sa = slope8(st_r.slope[0*SLOPE_W +: SLOPE_W]);
        sb = slope8(st_r.slope[1*SLOPE_W +: SLOPE_W]);
        sc = slope8(st_r.slope[2*SLOPE_W +: SLOPE_W]);
        sd = slope8(st_r.slope[3*SLOPE_W +: SLOPE_W]);
        t  = $signed({6'h00, st_r.temp});
        if (st_r.temp <= REG1_TOP) begin
            acc8 = -(14'sd48 * sb) - (14'sd48 - t) * sa;
        end else if (st_r.temp <= REG2_TOP) begin
            acc8 = -(14'sd96 - t) * sb;
        end else if (st_r.temp <= REG3_TOP) begin
            acc8 = (t - 14'sd96) * sc;
        end else if (st_r.temp <= REG4_TOP) begin
            acc8 = 14'sd47 * sc + (t - 14'sd143) * sd;
        end else begin
            acc8 = 14'sd47 * sc + 14'sd88 * sd;
        end
        rnd = (acc8 + 14'sd4) >>> 3;
        if (!st_r.ctrl[BIT_COMP_EN] || st_r.temp == TEMP_NONE) begin
            st_nxt.factor = 9'h000;
        end else if (rnd > 14'sd255) begin
            st_nxt.factor = 9'h0FF;
        end else if (rnd < -14'sd256) begin
            st_nxt.factor = 9'h100;
        end else begin
            st_nxt.factor = rnd[8:0];
        end

        // ************************************************************
        // Setpoint
        // ************************************************************
        active = st_r.ctrl[BIT_ICON_MODE] ? st_r.code_icon : st_r.code_char;
        sum    = $signed({2'b00, active}) + $signed({{2{st_r.factor[8]}}, st_r.factor});
        if (st_r.ctrl[BIT_EXT_SUPPLY]) begin
            st_nxt.setpoint = 10'h000;
        end else if (sum < 11'sd0) begin
            st_nxt.setpoint = 10'h000;
        end else if (sum > $signed({1'b0, SETPT_MAX})) begin
            st_nxt.setpoint = SETPT_MAX;
        end else begin
            st_nxt.setpoint = sum[9:0];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r           <= '0;
            st_r.ctrl      <= RST_CTRL;
            st_r.code_char <= RST_CODE;
            st_r.code_icon <= RST_CODE;
            st_r.slope     <= RST_SLOPE;
            st_r.temp      <= TEMP_NONE;
            st_r.meas      <= M_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_bresp         = st_r.bresp;
    assign s_axi_bvalid        = st_r.bvalid;
    assign s_axi_rdata         = st_r.rdata;
    assign s_axi_rresp         = st_r.rresp;
    assign s_axi_rvalid        = st_r.rvalid;
    assign sensor_active       = st_r.meas == M_CONV;
    // The pump follows its bit alone; software must keep it off with external supply.
    assign pump_enable         = st_r.ctrl[BIT_PUMP_EN];
    assign pump_multiplier_sel = st_r.ctrl[BIT_MULT_LO +: 2];
    assign internal_supply     = !st_r.ctrl[BIT_EXT_SUPPLY];
    assign lcd_setpoint_code   = st_r.setpoint;

endmodule

/* File: src/lcd_vcomp_pkg.sv */
// Constants, register map and types for the LCD voltage setpoint and temperature compensation.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package lcd_vcomp_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned MEAS_TIME_MS   = 8;
    localparam int unsigned MEAS_CYCLES    = MEAS_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned PERIOD_TIME_S  = 1;
    localparam int unsigned PERIOD_CYCLES  = PERIOD_TIME_S * CLK_HZ;
    localparam int          TICK_W         = 27;
    localparam int          CONV_W         = 20;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL        = 8'h00;
    localparam logic [7:0] OFF_CODE_CHAR   = 8'h04;
    localparam logic [7:0] OFF_CODE_ICON   = 8'h08;
    localparam logic [7:0] OFF_SLOPE       = 8'h0C;
    localparam logic [7:0] OFF_TEMP        = 8'h10;
    localparam logic [7:0] OFF_STATUS      = 8'h14;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int BIT_PUMP_EN     = 0;
    localparam int BIT_MULT_LO     = 1;
    localparam int BIT_MEAS_EN     = 3;
    localparam int BIT_FILT_EN     = 4;
    localparam int BIT_COMP_EN     = 5;
    localparam int BIT_ICON_MODE   = 6;
    localparam int BIT_EXT_SUPPLY  = 7;
    localparam int SLOPE_W         = 3;
    localparam int STAT_SETPT_LO   = 16;
    localparam int STAT_BUSY       = 31;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_CTRL   = 8'h00;
    localparam logic [8:0]  RST_CODE   = 9'h000;
    localparam logic [11:0] RST_SLOPE  = 12'h000;
    localparam logic [7:0]  TEMP_NONE  = 8'hFF;

    // ****************************************************************
    // Voltage scale and compensation regions
    // ****************************************************************
    localparam int          VLCD_BASE_MV = 4000;
    localparam int          VLCD_STEP_MV = 30;
    localparam int          VLCD_MAX_MV  = 16000;
    localparam logic [9:0]  SETPT_MAX    = 10'((VLCD_MAX_MV - VLCD_BASE_MV) / VLCD_STEP_MV);
    localparam logic [7:0]  REG1_TOP     = 8'h30;
    localparam logic [7:0]  REG2_TOP     = 8'h60;
    localparam logic [7:0]  REG3_TOP     = 8'h8F;
    localparam logic [7:0]  REG4_TOP     = 8'hE6;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_CONV = 2'b01,
        M_LOAD = 2'b11
    } meas_t;

endpackage

/* File: tb/lcd_vcomp_props.sv */
// Concurrent checks on the ports of the LCD setpoint block.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps

module lcd_vcomp_props #(
    parameter int unsigned MEAS_CYC   = 20,
    parameter int unsigned PERIOD_CYC = 100
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // AXI4-Lite
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Sensor and regulator
    input wire logic [7:0]  sensor_code,
    input wire logic        sensor_active,
    input wire logic        pump_enable,
    input wire logic [1:0]  pump_multiplier_sel,
    input wire logic        internal_supply,
    input wire logic [9:0]  lcd_setpoint_code
);
    import lcd_vcomp_pkg::*;

    // ****************************************************************
    // Conversion window length, counted because it is far beyond a repetition
    // ****************************************************************
    logic [31:0] act_cnt_r;
    logic [31:0] act_cnt_nxt;

    always_comb act_cnt_nxt = sensor_active ? act_cnt_r + 32'h1 : 32'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) act_cnt_r <= 32'h0;
        else act_cnt_r <= act_cnt_nxt;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_sense_len: assert property ($fell(sensor_active) |-> act_cnt_r == MEAS_CYC)
        else $error("conversion window length wrong");
    chk_sense_max: assert property (act_cnt_r <= MEAS_CYC)
        else $error("conversion window too long");
    chk_setpt_max: assert property (lcd_setpoint_code <= 10'h190)
        else $error("setpoint above the 16 V limit");
    chk_ext_zero: assert property (!internal_supply [*3] |-> lcd_setpoint_code == 10'h000)
        else $error("setpoint not zero with external supply");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    chk_bus_block: assert property (s_axi_bvalid || s_axi_rvalid |->
        !(s_axi_bvalid && (s_axi_awready || s_axi_wready)) && !(s_axi_rvalid && s_axi_arready))
        else $error("request accepted while an answer is pending");

    cover property ($fell(sensor_active));
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (lcd_setpoint_code == SETPT_MAX);
endmodule

/* File: tb/lcd_voltage_temp_compensation_bench.sv */
// Self-checking bench: AXI4-Lite host tasks and register-level scenarios.
// Assumes the design package, the sensor model and the checker are compiled first.
`timescale 1ns/1ps

module lcd_voltage_temp_compensation_bench;
    import lcd_vcomp_pkg::*;
    localparam int unsigned MEAS = 20;
    localparam int unsigned PER  = 100;
    localparam logic [31:0] SMASK = 32'h03FF_01FF;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, sensor_active, pump_enable, internal_supply;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pump_multiplier_sel, rsp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, sensor_code, temp_set;
    logic [9:0]  lcd_setpoint_code;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    int          err_total, samples_checked;
    int          temps [9] = '{0, 30, 51, 96, 120, 143, 200, 230, 240};

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    lcd_vcomp #(.MEAS_CYC(MEAS), .PERIOD_CYC(PER)) lcd_vcomp_inst (.*);

    sensor_model sensor_model_inst (.aclk(aclk), .sensor_active(sensor_active),
        .temp_target(temp_set), .sensor_code(sensor_code));

    // Slope codes in eighths, so every region formula stays in integers.
    function automatic int slope8(input logic [2:0] c);
        int tbl [8] = '{0, -1, -2, -4, -10, 1, 2, 4};
        return tbl[c];
    endfunction

    // Expected STATUS word, busy bit left out, from temperature, slopes, code and enable.
    function automatic logic [31:0] status_exp(input int t, input logic [11:0] s,
                                               input int code, input bit comp);
        int x, sp;
        if (t <= 48) x = -48 * slope8(s[5:3]) - (48 - t) * slope8(s[2:0]);
        else if (t <= 96) x = -(96 - t) * slope8(s[5:3]);
        else if (t <= 143) x = (t - 96) * slope8(s[8:6]);
        else if (t <= 230) x = 47 * slope8(s[8:6]) + (t - 143) * slope8(s[11:9]);
        else x = 47 * slope8(s[8:6]) + 88 * slope8(s[11:9]);
        x = (x + 4) >>> 3;
        x = (x > 255) ? 255 : ((x < -256) ? -256 : x);
        if (!comp) x = 0;
        sp = code + x;
        sp = (sp > 400) ? 400 : ((sp < 0) ? 0 : sp);
        return {6'h00, sp[9:0], 7'h00, x[8:0]};
    endfunction

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One AXI4-Lite transfer; each channel is released at the edge that takes it.
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
        bit hr;
        hr = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        for (int n = 0; n < 40 && !hr; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            hr = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            if (hr) {s_axi_bready, s_axi_rready} <= 2'b00;
        end
        if (!hr) begin
            err_total++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        xfer(1'b1, a, d);
        cmp_resp(rsp, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] r);
        xfer(1'b0, a, 32'h0000_0000);
        cmp_resp(rsp, r);
        cmp_word(q & m, e);
    endtask

    // Reads the temperature until it equals, or differs from, the given value.
    task automatic poll_temp(input logic [7:0] t, input bit eq);
        for (int n = 0; n < 100; n++) begin
            xfer(1'b0, OFF_TEMP, 32'h0000_0000);
            if ((q[7:0] === t) == eq) break;
        end
        if ((q[7:0] === t) != eq) begin
            err_total++;
            close_out();
        end
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, temp_set} = '0;
        s_axi_wstrb = 4'hF;
        err_total = 0;
        samples_checked = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_TEMP, 32'hFFFF_FFFF, 32'h0000_00FF, RESP_OKAY);
        rd(OFF_STATUS, SMASK, 32'h0000_0000, RESP_OKAY);
        wr(OFF_CTRL, 32'h0000_0007, RESP_OKAY);
        cmp_word({29'h0, pump_multiplier_sel, pump_enable}, 32'h0000_0007);
        wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
        cmp_word({29'h0, pump_multiplier_sel, pump_enable}, 32'h0000_0002);
        wr(OFF_CODE_CHAR, 32'hFFFF_FFFF, RESP_OKAY);
        wr(OFF_CODE_ICON, 32'h0000_0064, RESP_OKAY);
        rd(OFF_CODE_CHAR, 32'hFFFF_FFFF, 32'h0000_01FF, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp_word({22'h0, lcd_setpoint_code}, 32'h0000_0190);
        wr(OFF_CTRL, 32'h0000_0040, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp_word({22'h0, lcd_setpoint_code}, 32'h0000_0064);
        wr(OFF_CTRL, 32'h0000_00C0, RESP_OKAY);
        repeat (3) @(posedge aclk);
        cmp_word({21'h0, internal_supply, lcd_setpoint_code}, 32'h0000_0000);
        wr(8'h20, 32'h0000_0001, RESP_SLVERR);
        rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
        wr(OFF_TEMP, 32'h0000_0000, RESP_OKAY);
        rd(OFF_TEMP, 32'hFFFF_FFFF, 32'h0000_00FF, RESP_OKAY);
        // The code keeps the compensated voltage well above the analog supply.
        wr(OFF_CODE_CHAR, 32'h0000_00C8, RESP_OKAY);
        wr(OFF_SLOPE, 32'h0000_09CB, RESP_OKAY);
        wr(OFF_CTRL, 32'h0000_0028, RESP_OKAY);
        foreach (temps[i]) begin
            temp_set <= temps[i][7:0];
            poll_temp(temps[i][7:0], 1'b1);
            repeat (3) @(posedge aclk);
            rd(OFF_STATUS, SMASK, status_exp(temps[i], 12'h9CB, 200, 1'b1), RESP_OKAY);
        end
        for (int c = 0; c < 8; c++) begin
            wr(OFF_SLOPE, 32'(c << 6), RESP_OKAY);
            repeat (3) @(posedge aclk);
            rd(OFF_STATUS, SMASK, status_exp(240, 12'(c << 6), 200, 1'b1), RESP_OKAY);
        end
        wr(OFF_CTRL, 32'h0000_0008, RESP_OKAY);
        repeat (3) @(posedge aclk);
        rd(OFF_STATUS, SMASK, status_exp(240, 12'h1C0, 200, 1'b0), RESP_OKAY);
        wr(OFF_CTRL, 32'h0000_0018, RESP_OKAY);
        temp_set <= 8'h28;
        poll_temp(8'hF0, 1'b0);
        cmp_word({24'h0, q[7:0]}, 32'h0000_00BE);
        close_out();
    end
endmodule

bind lcd_vcomp lcd_vcomp_props #(.MEAS_CYC(MEAS_CYC), .PERIOD_CYC(PERIOD_CYC))
    lcd_vcomp_props_inst (.*);

/* File: tb/sensor_model.sv */
// Behavioural temperature sensor in place of the analog converter.
// Assumes the block samples the code in the cycle after sensor_active falls.
`timescale 1ns/1ps

module sensor_model (
    // Clock
    input  wire logic       aclk,
    // Conversion window and result
    input  wire logic       sensor_active,
    input  wire logic [7:0] temp_target,
    output logic      [7:0] sensor_code
);
    logic window_r;

    // Outside the window the code is inverted, so a sample taken too late cannot match.
    always_ff @(posedge aclk) window_r <= sensor_active;
    assign sensor_code = (sensor_active || window_r) ? temp_target : ~temp_target;
endmodule
